// File: logic/fbc_pkg.sv
// Constants, types and decode helpers shared by the synchronous up/down counter.
package fbc_pkg;

  // Counter width; raising it adds bits above the existing ones.
  localparam int unsigned FBC_WIDTH = 4;

  // Number of parallel load inputs and count outputs brought to pins.
  localparam int unsigned FBC_PIN_BITS = 4;

  // Select codes, written as {function_select_high, function_select_low}.
  localparam logic [1:0] FBC_SEL_CLEAR = 2'h0;
  localparam logic [1:0] FBC_SEL_LOAD  = 2'h1;
  localparam logic [1:0] FBC_SEL_COUNT = 2'h2;
  localparam logic [1:0] FBC_SEL_HOLD  = 2'h3;

  // Value of the count after reset and after a clear.
  localparam logic [FBC_WIDTH-1:0] FBC_COUNT_RESET = 4'h0;

  // All-ones pattern, the last value before an upward wrap.
  localparam logic [FBC_WIDTH-1:0] FBC_COUNT_ALL_ONES = 4'hf;

  typedef enum logic [1:0] {
    FBC_FN_CLEAR,
    FBC_FN_LOAD,
    FBC_FN_COUNT,
    FBC_FN_HOLD
  } fbc_func_e;

  typedef struct packed {
    logic [FBC_WIDTH-1:0] count;
    logic                 at_limit;
  } fbc_state_s;

  // Select decode, used by the datapath and by the checks.
  function automatic fbc_func_e fbc_decode_func(input logic [1:0] sel);
    fbc_func_e fn;
    case (sel)
      FBC_SEL_CLEAR: fn = FBC_FN_CLEAR;
      FBC_SEL_LOAD:  fn = FBC_FN_LOAD;
      FBC_SEL_COUNT: fn = FBC_FN_COUNT;
      FBC_SEL_HOLD:  fn = FBC_FN_HOLD;
      default:       fn = FBC_FN_HOLD;
    endcase
    return fn;
  endfunction : fbc_decode_func

endpackage : fbc_pkg

// File: logic/fbc_bit_cell.sv
// Next-value logic for one counter bit.
`timescale 1ns/10ps
module fbc_bit_cell
  import fbc_pkg::*;
(
  // Present state of this bit and of the bits below it
  input  wire logic      cur_bit,
  input  wire logic      lower_all_ones,
  input  wire logic      lower_all_zeros,
  // Function, direction and load data
  input  wire fbc_func_e func,
  input  wire logic      count_down,
  input  wire logic      load_bit,
  // Value presented to this bit's flip-flop
  output logic           nxt_bit
);

  logic toggle;

  always_comb
  begin
    // The direction picks which run of lower bits enables the toggle.
    toggle = count_down ? lower_all_zeros : lower_all_ones;
    case (func)
      FBC_FN_CLEAR: nxt_bit = 1'b0;
      FBC_FN_LOAD:  nxt_bit = load_bit;
      FBC_FN_COUNT: nxt_bit = toggle ? ~cur_bit : cur_bit;
      FBC_FN_HOLD:  nxt_bit = cur_bit;
      default:      nxt_bit = cur_bit;
    endcase
  end

endmodule : fbc_bit_cell

// File: logic/fbc_counter.sv
// Synchronous binary counter with clear, load, count and hold functions.
`timescale 1ns/10ps
module fbc_counter
  import fbc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Function select
  input  wire logic function_select_high,
  input  wire logic function_select_low,
  // Counting direction; low counts up
  input  wire logic count_down,
  // Parallel load data
  input  wire logic load_value_bit0,
  input  wire logic load_value_bit1,
  input  wire logic load_value_bit2,
  input  wire logic load_value_bit3,
  // Counter state
  output logic      count_value_bit0,
  output logic      count_value_bit1,
  output logic      count_value_bit2,
  output logic      count_value_bit3,
  // High when the count set at the last edge is the last value in the direction sampled at that edge; low after reset
  output logic      count_at_limit
);

  fbc_state_s state_ff;
  fbc_state_s nxt_state;

  fbc_func_e            func;
  logic [FBC_WIDTH-1:0] load_vec;
  logic [FBC_WIDTH-1:0] nxt_count;
  logic [FBC_WIDTH:0]   ones_chain;
  logic [FBC_WIDTH:0]   zeros_chain;

  assign func = fbc_decode_func({function_select_high, function_select_low});

  // Bits above the pin group have no load input and load zero.
  always_comb
  begin
    load_vec    = '0;
    load_vec[0] = load_value_bit0;
    load_vec[1] = load_value_bit1;
    load_vec[2] = load_value_bit2;
    load_vec[3] = load_value_bit3;
  end

  // The lowest bit sees an empty run below it, so it toggles on every count.
  assign ones_chain[0]  = 1'b1;
  assign zeros_chain[0] = 1'b1;

  // Each bit only looks at the bits below it, so a new top bit leaves the
  // lower cells untouched. The ripple chain costs depth; at this width it is
  // far inside one period.
  genvar gi;
  generate
    for (gi = 0; gi < FBC_WIDTH; gi++)
    begin : g_bit
      assign ones_chain[gi+1]  = ones_chain[gi] & state_ff.count[gi];
      assign zeros_chain[gi+1] = zeros_chain[gi] & ~state_ff.count[gi];

      fbc_bit_cell u_cell (
        .cur_bit         (state_ff.count[gi]),
        .lower_all_ones  (ones_chain[gi]),
        .lower_all_zeros (zeros_chain[gi]),
        .func            (func),
        .count_down      (count_down),
        .load_bit        (load_vec[gi]),
        .nxt_bit         (nxt_count[gi])
      );
    end
  endgenerate

  always_comb
  begin
    nxt_state          = state_ff;
    nxt_state.count    = nxt_count;
    nxt_state.at_limit = count_down ? (nxt_count == FBC_COUNT_RESET)
                                    : (nxt_count == FBC_COUNT_ALL_ONES);
  end

  // One register for the whole state: every bit moves on the same edge.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff.count    <= FBC_COUNT_RESET;
      state_ff.at_limit <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign count_value_bit0 = state_ff.count[0];
  assign count_value_bit1 = state_ff.count[1];
  assign count_value_bit2 = state_ff.count[2];
  assign count_value_bit3 = state_ff.count[3];
  assign count_at_limit   = state_ff.at_limit;

  // Checks.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Rebuilt from the pins, so the checks see what a user of the block sees.
  logic [FBC_PIN_BITS-1:0] obs_count;
  assign obs_count = {count_value_bit3, count_value_bit2, count_value_bit1, count_value_bit0};

  property p_clear;
    func == FBC_FN_CLEAR |=> obs_count == FBC_COUNT_RESET;
  endproperty
  a_clear: assert property (p_clear)
    else $error("Clear select did not zero the count.");

  property p_load;
    func == FBC_FN_LOAD |=> obs_count == $past(load_vec);
  endproperty
  a_load: assert property (p_load)
    else $error("Load select did not capture the load data.");

  property p_hold;
    func == FBC_FN_HOLD |=> $stable(obs_count);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Hold select changed the count.");

  property p_up_step;
    (func == FBC_FN_COUNT && !count_down)
      |=> obs_count == FBC_WIDTH'($past(obs_count) + 1'b1);
  endproperty
  a_up_step: assert property (p_up_step)
    else $error("Up count did not advance by one.");

  property p_down_step;
    (func == FBC_FN_COUNT && count_down)
      |=> obs_count == FBC_WIDTH'($past(obs_count) - 1'b1);
  endproperty
  a_down_step: assert property (p_down_step)
    else $error("Down count did not step back by one.");

  property p_lsb_toggle;
    func == FBC_FN_COUNT |=> count_value_bit0 != $past(count_value_bit0);
  endproperty
  a_lsb_toggle: assert property (p_lsb_toggle)
    else $error("Lowest bit failed to toggle while counting.");

  property p_top_toggle;
    (func == FBC_FN_COUNT && !count_down)
      |=> (count_value_bit3 != $past(count_value_bit3)) == (&$past(obs_count[2:0]));
  endproperty
  a_top_toggle: assert property (p_top_toggle)
    else $error("Top bit toggle did not match the lower bits.");

  property p_keep_upper;
    (func == FBC_FN_COUNT && !count_down && !count_value_bit0)
      |=> obs_count[FBC_WIDTH-1:1] == $past(obs_count[FBC_WIDTH-1:1]);
  endproperty
  a_keep_upper: assert property (p_keep_upper)
    else $error("Upper bits changed without a toggle condition.");

  property p_wrap;
    (func == FBC_FN_COUNT && !count_down && obs_count == FBC_COUNT_ALL_ONES)
      |=> obs_count == FBC_COUNT_RESET;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("Count did not wrap from all ones to zero.");

  property p_down_wrap;
    (func == FBC_FN_COUNT && count_down && obs_count == FBC_COUNT_RESET)
      |=> obs_count == FBC_COUNT_ALL_ONES;
  endproperty
  a_down_wrap: assert property (p_down_wrap)
    else $error("Down count did not wrap from zero to all ones.");

  property p_down_top_toggle;
    (func == FBC_FN_COUNT && count_down)
      |=> (count_value_bit3 != $past(count_value_bit3)) == (~|$past(obs_count[2:0]));
  endproperty
  a_down_top_toggle: assert property (p_down_top_toggle)
    else $error("Top bit toggle did not match the lower zeros while counting down.");

  property p_bit1_toggle;
    (func == FBC_FN_COUNT && !count_down)
      |=> (count_value_bit1 != $past(count_value_bit1)) == $past(count_value_bit0);
  endproperty
  a_bit1_toggle: assert property (p_bit1_toggle)
    else $error("Second bit toggle did not follow the lowest bit.");

  property p_count_run;
    (func == FBC_FN_COUNT && !count_down)[*3]
      |=> obs_count == FBC_WIDTH'($past(obs_count, 3) + 2'h3);
  endproperty
  a_count_run: assert property (p_count_run)
    else $error("Three up counts did not add three.");

  property p_limit_flag;
    ##1 count_at_limit == (count_down ? (obs_count == FBC_COUNT_RESET)
                                      : (obs_count == FBC_COUNT_ALL_ONES))
      || $changed(count_down);
  endproperty
  a_limit_flag: assert property (p_limit_flag)
    else $error("Limit flag disagrees with the count.");

  property p_cover_wrap;
    (func == FBC_FN_COUNT && !count_down && obs_count == FBC_COUNT_ALL_ONES)
      ##1 obs_count == FBC_COUNT_RESET;
  endproperty
  c_cover_wrap: cover property (p_cover_wrap);

  property p_cover_load_count;
    func == FBC_FN_LOAD ##1 func == FBC_FN_COUNT [*2] ##1 func == FBC_FN_HOLD;
  endproperty
  c_cover_load_count: cover property (p_cover_load_count);

  property p_cover_down_wrap;
    (func == FBC_FN_COUNT && count_down && obs_count == FBC_COUNT_RESET)
      ##1 obs_count == FBC_COUNT_ALL_ONES;
  endproperty
  c_cover_down_wrap: cover property (p_cover_down_wrap);

  property p_cover_limit_rise;
    $rose(count_at_limit);
  endproperty
  c_cover_limit_rise: cover property (p_cover_limit_rise);

endmodule : fbc_counter

// File: tb/fbc_counter_tb_top.sv
// Self-checking testbench for the synchronous counter with clear, load, count and hold.
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) \
    begin \
      failures++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
  end
module fbc_counter_tb_top
  import fbc_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic [1:0] sel;
  logic       down;
  logic [3:0] ld;
  wire  [3:0] q;
  wire        lim;
  int         failures;
  int         checks;

  fbc_counter dut (
    .clk                  (clk),
    .rst_n                (rst_n),
    .function_select_high (sel[1]),
    .function_select_low  (sel[0]),
    .count_down           (down),
    .load_value_bit0      (ld[0]),
    .load_value_bit1      (ld[1]),
    .load_value_bit2      (ld[2]),
    .load_value_bit3      (ld[3]),
    .count_value_bit0     (q[0]),
    .count_value_bit1     (q[1]),
    .count_value_bit2     (q[2]),
    .count_value_bit3     (q[3]),
    .count_at_limit       (lim)
  );

  always #2 clk = ~clk;

  task automatic end_of_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // One function for one edge, then back to hold so a later edge cannot repeat it.
  task automatic op(input logic [1:0] s, input logic dn, input logic [3:0] d,
                    input logic [3:0] e);
    @(posedge clk);
    sel <= s;
    down <= dn;
    ld <= d;
    @(posedge clk);
    sel <= FBC_SEL_HOLD;
    @(negedge clk);
    `CHK(q, e)
    `CHK(lim, dn ? (e === 4'h0) : (e === 4'hf))
  endtask : op

  task automatic t_load_all();
    for (int i = 0; i < 16; i++)
      op(FBC_SEL_LOAD, i[0], 4'(i), 4'(i));
  endtask : t_load_all

  task automatic t_up_sweep();
    op(FBC_SEL_CLEAR, 1'b0, 4'h9, 4'h0);
    for (int i = 1; i <= 17; i++)
      op(FBC_SEL_COUNT, 1'b0, 4'h5, 4'(i));
  endtask : t_up_sweep

  task automatic t_down();
    op(FBC_SEL_LOAD, 1'b1, 4'h2, 4'h2);
    for (int i = 1; i <= 4; i++)
      op(FBC_SEL_COUNT, 1'b1, 4'h0, 4'(2 - i));
  endtask : t_down

  task automatic t_hold();
    op(FBC_SEL_LOAD, 1'b0, 4'ha, 4'ha);
    for (int i = 0; i < 4; i++)
      op(FBC_SEL_HOLD, i[0], ~4'(i), 4'ha);
  endtask : t_hold

  task automatic t_clear();
    op(FBC_SEL_LOAD, 1'b0, 4'hf, 4'hf);
    op(FBC_SEL_CLEAR, 1'b0, 4'hf, 4'h0);
  endtask : t_clear

  // Load, then two counts on consecutive edges; the second one wraps.
  task automatic t_back_to_back();
    @(posedge clk);
    sel <= FBC_SEL_LOAD;
    ld <= 4'he;
    down <= 1'b1;
    @(posedge clk);
    sel <= FBC_SEL_COUNT;
    down <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    sel <= FBC_SEL_HOLD;
    @(negedge clk);
    `CHK(q, 4'h0)
    `CHK(lim, 1'b0)
  endtask : t_back_to_back

  // Reset in mid-run clears at once, and a count on the second edge after release acts.
  task automatic t_reset_mid();
    op(FBC_SEL_LOAD, 1'b0, 4'h5, 4'h5);
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    `CHK(q, 4'h0)
    @(posedge clk);
    rst_n <= 1'b1;
    op(FBC_SEL_COUNT, 1'b0, 4'h0, 4'h1);
  endtask : t_reset_mid

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    sel = FBC_SEL_HOLD;
    down = 1'b0;
    ld = 4'h0;
    failures = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK(q, 4'h0)
    t_load_all();
    t_up_sweep();
    t_down();
    t_hold();
    t_clear();
    t_back_to_back();
    t_reset_mid();
    end_of_test();
  end

  // The tests take about 120 cycles; 5000 cycles means a hang.
  initial
  begin
    #20000;
    failures++;
    end_of_test();
  end
endmodule : fbc_counter_tb_top
